/* src/srf_defines.vh */
// Constants for the sample-record writer and the off-core response filter.
`ifndef SRF_DEFINES_VH
`define SRF_DEFINES_VH

// Sample record word offsets, in bytes.
`define SRF_OFS_NEXT_IP 8'h08
`define SRF_OFS_LIN_ADDR 8'h98
`define SRF_OFS_ST_STATUS 8'hA0
`define SRF_OFS_RSVD_ZERO 8'hA8
`define SRF_OFS_TRIG_IP 8'hB0
`define SRF_OFS_NONE 8'h00

// Record word layout.
`define SRF_WORD_W 64
`define SRF_ST_L1_HIT 0
`define SRF_WORD_ZERO 64'h0000000000000000

// Off-core response filter layout.
`define SRF_FILT_W 38
`define SRF_REQ_MSB 15
`define SRF_REQ_LSB 0
`define SRF_SUP_MSB 30
`define SRF_SUP_LSB 16
`define SRF_SUP_ANY 16
`define SRF_SUP_SPEC_LSB 17
`define SRF_SNP_MSB 37
`define SRF_SNP_LSB 31
`define SRF_FILT_RESET 38'h0000000000
`define SRF_SNP_NONE 7'h00

// Request-type select bit positions.
`define SRF_REQ_DEMAND_DATA 0
`define SRF_REQ_DEMAND_OWN 1
`define SRF_REQ_DEMAND_CODE 2
`define SRF_REQ_MOD_WB 3
`define SRF_REQ_L2PF_DATA 4
`define SRF_REQ_L2PF_OWN 5
`define SRF_REQ_L2PF_CODE 6
`define SRF_REQ_L3PF_DATA 7
`define SRF_REQ_L3PF_OWN 8
`define SRF_REQ_L3PF_CODE 9
`define SRF_REQ_SPLIT_UC 10
`define SRF_REQ_STREAM_STORE 11
`define SRF_REQ_OTHER 15

// Supplier select bit positions.
`define SRF_SUP_NO_INFO 17
`define SRF_SUP_LLC_HIT_M 18
`define SRF_SUP_LLC_HIT_E 19
`define SRF_SUP_LLC_HIT_S 20
`define SRF_SUP_LLC_HIT_F 21
`define SRF_SUP_LOCAL_MEM 22
`define SRF_SUP_L4_LOCAL 22
`define SRF_SUP_L4_HOP0 23
`define SRF_SUP_L4_HOP1 24
`define SRF_SUP_L4_HOP2P 25
`define SRF_SUP_REMOTE_HOP0 27
`define SRF_SUP_REMOTE_HOP1 28
`define SRF_SUP_REMOTE_HOP2P 29

// Product variants of the supplier field.
`define SRF_VAR_CLIENT 2'h0
`define SRF_VAR_L4 2'h1
`define SRF_VAR_SERVER 2'h2

// Implemented (writable) filter bits per variant; all others are reserved.
`define SRF_MASK_CLIENT 38'h3F805F8FFF
`define SRF_MASK_L4 38'h3F83DF8FFF
`define SRF_MASK_SERVER 38'h3FB87F8FFF

`endif

/* src/srf_cap_reg.v */
// Capture register that samples a value on a load strobe.
`timescale 1ns/1ps
module srf_cap_reg #(
    parameter W = 64
) (
    input wire clk, // Core clock.
    input wire rst, // Synchronous reset, active high.
    input wire load, // Capture strobe.
    input wire [W-1:0] d, // Value to capture.
    output wire [W-1:0] q // Captured value.
);
    reg [W-1:0] val_ff;

    always @(posedge clk) begin
        if (rst) begin
            val_ff <= {W{1'b0}};
        end else if (load) begin
            val_ff <= d;
        end
    end

    assign q = val_ff;
endmodule

/* src/srf_ocr_match.v */
// Combinational match of one transaction against the off-core response filter.
`timescale 1ns/1ps
`include "srf_defines.vh"
module srf_ocr_match (
    input wire [`SRF_FILT_W-1:0] filt, // Filter register value.
    input wire [`SRF_REQ_MSB:`SRF_REQ_LSB] req, // One-hot request type.
    input wire [`SRF_SUP_MSB:`SRF_SUP_SPEC_LSB] sup, // Supplier flags.
    input wire [`SRF_SNP_MSB-`SRF_SNP_LSB:0] snp, // Snoop response flags.
    output wire hit // Transaction matches the filter.
);
    wire req_hit;
    wire sup_hit;
    wire snp_hit;
    wire [`SRF_SNP_MSB-`SRF_SNP_LSB:0] snp_sel;

    assign req_hit = |(req & filt[`SRF_REQ_MSB:`SRF_REQ_LSB]);
    assign sup_hit = filt[`SRF_SUP_ANY] | (|(sup & filt[`SRF_SUP_MSB:`SRF_SUP_SPEC_LSB]));
    assign snp_sel = filt[`SRF_SNP_MSB:`SRF_SNP_LSB];
    // The snoop encoding is kept outside this block, so an empty selection passes all.
    assign snp_hit = (snp_sel == `SRF_SNP_NONE) | (|(snp & snp_sel));
    assign hit = req_hit & sup_hit & snp_hit;
endmodule

/* src/srf_sample_filter.v */
// Sample record word writer with the off-core response filter register.
`timescale 1ns/1ps
`include "srf_defines.vh"
module srf_sample_filter #(
    parameter [1:0] VARIANT = `SRF_VAR_CLIENT
) (
    input wire REF_CLK, // Core clock.
    input wire SYS_RST, // Synchronous reset, active high.
    input wire DATA_ADDR_PROFILING, // Data address profiling enabled.
    input wire CNT_OVF, // Sampling counter overflow pulse.
    input wire [`SRF_WORD_W-1:0] RET_LIN_ADDR, // Retiring memory op address.
    input wire RET_IS_STORE, // Retiring memory op is a store.
    input wire RET_L1_HIT, // Store hit the level-one data cache.
    input wire RET_STORE_EVT, // Counter is programmed with a listed store event.
    input wire [`SRF_WORD_W-1:0] RET_TRIG_IP, // Pointer of triggering instruction.
    input wire [`SRF_WORD_W-1:0] RET_NEXT_IP, // Pointer of next instruction.
    output reg REC_BUSY, // Record generation in progress.
    output reg REC_VALID, // Record word write strobe.
    output reg [7:0] REC_OFFSET, // Record word byte offset.
    output reg [`SRF_WORD_W-1:0] REC_DATA, // Record word data.
    input wire MSR_WR, // Filter register write strobe.
    input wire [`SRF_FILT_W-1:0] MSR_WDATA, // Filter register write data.
    output reg [`SRF_FILT_W-1:0] MSR_RDATA, // Filter register contents.
    input wire TXN_VALID, // Off-core transaction response present.
    input wire [`SRF_REQ_MSB:`SRF_REQ_LSB] TXN_REQ, // One-hot request type.
    input wire [`SRF_SUP_MSB:`SRF_SUP_SPEC_LSB] TXN_SUP, // Supplier flags.
    input wire [`SRF_SNP_MSB-`SRF_SNP_LSB:0] TXN_SNP, // Snoop response flags.
    output reg OCR_MATCH // Transaction matched the filter.
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_NIP = 6'h02;
    localparam [5:0] ST_LA = 6'h04;
    localparam [5:0] ST_SS = 6'h08;
    localparam [5:0] ST_RZ = 6'h10;
    localparam [5:0] ST_TIP = 6'h20;

    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg dla_ff;
    reg nxt_dla;
    reg nxt_valid;
    reg [7:0] nxt_offset;
    reg [`SRF_WORD_W-1:0] nxt_data;
    reg [`SRF_FILT_W-1:0] nxt_filt;
    reg [`SRF_FILT_W-1:0] impl_mask;

    wire take;
    wire st_hit;
    wire st_hit_q;
    wire match_w;
    wire [`SRF_WORD_W-1:0] lin_addr_q;
    wire [`SRF_WORD_W-1:0] trig_ip_q;
    wire [`SRF_WORD_W-1:0] next_ip_q;

    // An overflow seen while a record is still being written is dropped;
    // the captured operands must stay stable until the last word leaves.
    assign take = CNT_OVF & state_ff[0];

    // Only a store under a listed store event reports a hit; otherwise zero.
    assign st_hit = RET_IS_STORE & RET_STORE_EVT & RET_L1_HIT;

    srf_cap_reg #(
        .W(`SRF_WORD_W)
    ) u_lin_addr (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load(take),
        .d(RET_LIN_ADDR),
        .q(lin_addr_q)
    );

    srf_cap_reg #(
        .W(`SRF_WORD_W)
    ) u_trig_ip (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load(take),
        .d(RET_TRIG_IP),
        .q(trig_ip_q)
    );

    srf_cap_reg #(
        .W(`SRF_WORD_W)
    ) u_next_ip (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load(take),
        .d(RET_NEXT_IP),
        .q(next_ip_q)
    );

    srf_cap_reg #(
        .W(1)
    ) u_st_hit (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load(take),
        .d(st_hit),
        .q(st_hit_q)
    );

    // Record sequencer: words go out in offset order, one per cycle.
    always @* begin
        nxt_state = state_ff;
        nxt_dla = dla_ff;
        nxt_valid = 1'b0;
        nxt_offset = `SRF_OFS_NONE;
        nxt_data = `SRF_WORD_ZERO;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_dla = DATA_ADDR_PROFILING;
                    nxt_state = ST_NIP;
                end
            end
            ST_NIP: begin
                nxt_valid = 1'b1;
                nxt_offset = `SRF_OFS_NEXT_IP;
                nxt_data = next_ip_q;
                if (dla_ff) begin
                    nxt_state = ST_LA;
                end else begin
                    nxt_state = ST_TIP;
                end
            end
            ST_LA: begin
                nxt_valid = 1'b1;
                nxt_offset = `SRF_OFS_LIN_ADDR;
                nxt_data = lin_addr_q;
                nxt_state = ST_SS;
            end
            ST_SS: begin
                nxt_valid = 1'b1;
                nxt_offset = `SRF_OFS_ST_STATUS;
                nxt_data = `SRF_WORD_ZERO;
                nxt_data[`SRF_ST_L1_HIT] = st_hit_q;
                nxt_state = ST_RZ;
            end
            ST_RZ: begin
                nxt_valid = 1'b1;
                nxt_offset = `SRF_OFS_RSVD_ZERO;
                nxt_data = `SRF_WORD_ZERO;
                nxt_state = ST_TIP;
            end
            ST_TIP: begin
                nxt_valid = 1'b1;
                nxt_offset = `SRF_OFS_TRIG_IP;
                nxt_data = trig_ip_q;
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_ff <= ST_IDLE;
            dla_ff <= 1'b0;
            REC_BUSY <= 1'b0;
            REC_VALID <= 1'b0;
            REC_OFFSET <= `SRF_OFS_NONE;
            REC_DATA <= `SRF_WORD_ZERO;
        end else begin
            state_ff <= nxt_state;
            dla_ff <= nxt_dla;
            REC_BUSY <= ~nxt_state[0];
            REC_VALID <= nxt_valid;
            REC_OFFSET <= nxt_offset;
            REC_DATA <= nxt_data;
        end
    end

    // Implemented filter bits are built field by field for the product variant.
    // Anything not set here is reserved and is dropped at write time.
    always @* begin
        impl_mask = {`SRF_FILT_W{1'b0}};

        impl_mask[`SRF_REQ_DEMAND_DATA] = 1'b1;
        impl_mask[`SRF_REQ_DEMAND_OWN] = 1'b1;
        impl_mask[`SRF_REQ_DEMAND_CODE] = 1'b1;
        impl_mask[`SRF_REQ_MOD_WB] = 1'b1;
        impl_mask[`SRF_REQ_L2PF_DATA] = 1'b1;
        impl_mask[`SRF_REQ_L2PF_OWN] = 1'b1;
        impl_mask[`SRF_REQ_L2PF_CODE] = 1'b1;
        impl_mask[`SRF_REQ_L3PF_DATA] = 1'b1;
        impl_mask[`SRF_REQ_L3PF_OWN] = 1'b1;
        impl_mask[`SRF_REQ_L3PF_CODE] = 1'b1;
        impl_mask[`SRF_REQ_SPLIT_UC] = 1'b1;
        impl_mask[`SRF_REQ_STREAM_STORE] = 1'b1;
        impl_mask[`SRF_REQ_OTHER] = 1'b1;

        // The snoop field is taken whole; its encoding is interpreted elsewhere.
        impl_mask[`SRF_SNP_MSB:`SRF_SNP_LSB] = {(`SRF_SNP_MSB-`SRF_SNP_LSB+1){1'b1}};

        impl_mask[`SRF_SUP_ANY] = 1'b1;
        impl_mask[`SRF_SUP_NO_INFO] = 1'b1;
        impl_mask[`SRF_SUP_LLC_HIT_M] = 1'b1;
        impl_mask[`SRF_SUP_LLC_HIT_E] = 1'b1;
        impl_mask[`SRF_SUP_LLC_HIT_S] = 1'b1;

        case (VARIANT)
            `SRF_VAR_L4: begin
                impl_mask[`SRF_SUP_L4_LOCAL] = 1'b1;
                impl_mask[`SRF_SUP_L4_HOP0] = 1'b1;
                impl_mask[`SRF_SUP_L4_HOP1] = 1'b1;
                impl_mask[`SRF_SUP_L4_HOP2P] = 1'b1;
            end
            `SRF_VAR_SERVER: begin
                impl_mask[`SRF_SUP_LLC_HIT_F] = 1'b1;
                impl_mask[`SRF_SUP_LOCAL_MEM] = 1'b1;
                impl_mask[`SRF_SUP_REMOTE_HOP0] = 1'b1;
                impl_mask[`SRF_SUP_REMOTE_HOP1] = 1'b1;
                impl_mask[`SRF_SUP_REMOTE_HOP2P] = 1'b1;
            end
            default: begin
                impl_mask[`SRF_SUP_LOCAL_MEM] = 1'b1;
            end
        endcase
    end

    // Request bits 0-11 and 15 are kept, 14:12 dropped by the mask.
    // Masking at write time means reserved bits can never reach matching.
    always @* begin
        nxt_filt = MSR_RDATA;
        if (MSR_WR) begin
            nxt_filt = MSR_WDATA & impl_mask;
        end
    end

    // The field split itself lives in the matcher below.
    srf_ocr_match u_match (
        .filt(MSR_RDATA),
        .req(TXN_REQ),
        .sup(TXN_SUP),
        .snp(TXN_SNP),
        .hit(match_w)
    );

    // Request selects 4-9 and 10, 11, 15 behave like 0-3: one bit per type.
    always @(posedge REF_CLK) begin
        if (SYS_RST) begin
            MSR_RDATA <= `SRF_FILT_RESET;
            OCR_MATCH <= 1'b0;
        end else begin
            MSR_RDATA <= nxt_filt;
            OCR_MATCH <= TXN_VALID & match_w;
        end
    end
endmodule

/* bench/srf_sample_filter_checker.sv */
// Assertion checker for the sample-record writer and off-core filter.
`timescale 1ns/1ps
`include "srf_defines.vh"
module srf_sample_filter_checker #(
    parameter [1:0] VARIANT = `SRF_VAR_CLIENT
) (
    input wire REF_CLK, // clock
    input wire SYS_RST, // reset
    input wire DATA_ADDR_PROFILING, // enable
    input wire CNT_OVF, // overflow
    input wire [63:0] RET_LIN_ADDR, // address
    input wire RET_IS_STORE, // store
    input wire RET_L1_HIT, // hit
    input wire RET_STORE_EVT, // event
    input wire [63:0] RET_TRIG_IP, // ip
    input wire [63:0] RET_NEXT_IP, // ip
    input wire REC_BUSY, // busy
    input wire REC_VALID, // strobe
    input wire [7:0] REC_OFFSET, // offset
    input wire [63:0] REC_DATA, // data
    input wire MSR_WR, // write
    input wire [37:0] MSR_WDATA, // data
    input wire [37:0] MSR_RDATA, // contents
    input wire TXN_VALID, // txn
    input wire [15:0] TXN_REQ, // request
    input wire [13:0] TXN_SUP, // supplier
    input wire [6:0] TXN_SNP, // snoop
    input wire OCR_MATCH // match
);
    localparam [37:0] MASK = VARIANT == `SRF_VAR_SERVER ? `SRF_MASK_SERVER :
        VARIANT == `SRF_VAR_L4 ? `SRF_MASK_L4 : `SRF_MASK_CLIENT;
    wire start = CNT_OVF && !REC_BUSY;
    wire sth = RET_IS_STORE && RET_STORE_EVT && RET_L1_HIT;
    wire [37:0] f = MSR_RDATA;
    wire exp_hit = (|(TXN_REQ & f[15:0])) && (f[16] || |(TXN_SUP & f[30:17])) &&
        (f[37:31] == 7'h00 || |(TXN_SNP & f[37:31]));
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    a_prof_order: assert property (start && DATA_ADDR_PROFILING |->
        ##2 REC_VALID && REC_OFFSET == 8'h08 && REC_DATA == $past(RET_NEXT_IP, 2)
        ##1 REC_VALID && REC_OFFSET == 8'h98 && REC_DATA == $past(RET_LIN_ADDR, 3)
        ##1 REC_VALID && REC_OFFSET == 8'hA0 ##1 REC_VALID && REC_OFFSET == 8'hA8 && REC_DATA == 64'h0
        ##1 REC_VALID && REC_OFFSET == 8'hB0 && REC_DATA == $past(RET_TRIG_IP, 6)) else $error("profiled order");
    a_plain_order: assert property (start && !DATA_ADDR_PROFILING |->
        ##2 REC_VALID && REC_OFFSET == 8'h08 ##1 REC_VALID && REC_OFFSET == 8'hB0 ##1 !REC_VALID)
        else $error("plain order");
    a_store_hit_set: assert property (start && DATA_ADDR_PROFILING && sth |-> ##4 REC_DATA == 64'h1)
        else $error("store hit bit");
    a_store_bits_zero: assert property (start && DATA_ADDR_PROFILING && !sth |-> ##4 REC_DATA == 64'h0)
        else $error("store status nonzero");
    a_busy_follows: assert property (start |=> REC_BUSY) else $error("busy missing");
    a_idle_quiet: assert property (!REC_VALID |-> REC_OFFSET == 8'h00 && REC_DATA == 64'h0)
        else $error("idle word");
    a_filt_write: assert property (MSR_WR |=> MSR_RDATA == ($past(MSR_WDATA) & MASK))
        else $error("filter write");
    a_filt_hold: assert property (!MSR_WR |=> $stable(MSR_RDATA)) else $error("filter drift");
    a_match_calc: assert property (TXN_VALID |=> OCR_MATCH == $past(exp_hit))
        else $error("match value");
    a_match_quiet: assert property (!TXN_VALID |=> !OCR_MATCH) else $error("stray match");
endmodule
bind srf_sample_filter srf_sample_filter_checker #(.VARIANT(VARIANT)) srf_chk_i (.REF_CLK, .SYS_RST,
    .DATA_ADDR_PROFILING, .CNT_OVF, .RET_LIN_ADDR, .RET_IS_STORE, .RET_L1_HIT, .RET_STORE_EVT, .RET_TRIG_IP,
    .RET_NEXT_IP, .REC_BUSY, .REC_VALID, .REC_OFFSET, .REC_DATA, .MSR_WR, .MSR_WDATA, .MSR_RDATA,
    .TXN_VALID, .TXN_REQ, .TXN_SUP, .TXN_SNP, .OCR_MATCH);

/* bench/tb_top.sv */
// Self-checking testbench for the sample-record writer and off-core filter.
`timescale 1ns/1ps
`include "srf_defines.vh"
module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg dap = 1'b0, ovf = 1'b0, st = 1'b0, ev = 1'b0, hit = 1'b0, mwr = 1'b0, tv = 1'b0;
    reg [63:0] la = 64'h0, tip = 64'h0, nip = 64'h0;
    reg [37:0] mwd = 38'h0;
    reg [15:0] req = 16'h0;
    reg [13:0] sup = 14'h0;
    reg [6:0] snp = 7'h0;
    wire busy, vld, om, om_l4, om_srv;
    wire [7:0] ofs;
    wire [63:0] dat;
    wire [37:0] rd, rd_l4, rd_srv;
    integer error_cnt = 0, check_count = 0, cyc = 0, n;
    srf_sample_filter srf_sample_filter_i (.REF_CLK(clk), .SYS_RST(rst), .DATA_ADDR_PROFILING(dap),
        .CNT_OVF(ovf), .RET_LIN_ADDR(la), .RET_IS_STORE(st), .RET_L1_HIT(hit), .RET_STORE_EVT(ev),
        .RET_TRIG_IP(tip), .RET_NEXT_IP(nip), .REC_BUSY(busy), .REC_VALID(vld), .REC_OFFSET(ofs),
        .REC_DATA(dat), .MSR_WR(mwr), .MSR_WDATA(mwd), .MSR_RDATA(rd), .TXN_VALID(tv), .TXN_REQ(req),
        .TXN_SUP(sup), .TXN_SNP(snp), .OCR_MATCH(om));
    srf_sample_filter #(.VARIANT(`SRF_VAR_L4)) srf_sample_filter_l4_i (.REF_CLK(clk), .SYS_RST(rst),
        .DATA_ADDR_PROFILING(dap), .CNT_OVF(ovf), .RET_LIN_ADDR(la), .RET_IS_STORE(st), .RET_L1_HIT(hit),
        .RET_STORE_EVT(ev), .RET_TRIG_IP(tip), .RET_NEXT_IP(nip), .REC_BUSY(), .REC_VALID(), .REC_OFFSET(),
        .REC_DATA(), .MSR_WR(mwr), .MSR_WDATA(mwd), .MSR_RDATA(rd_l4), .TXN_VALID(tv), .TXN_REQ(req),
        .TXN_SUP(sup), .TXN_SNP(snp), .OCR_MATCH(om_l4));
    srf_sample_filter #(.VARIANT(`SRF_VAR_SERVER)) srf_sample_filter_srv_i (.REF_CLK(clk), .SYS_RST(rst),
        .DATA_ADDR_PROFILING(dap), .CNT_OVF(ovf), .RET_LIN_ADDR(la), .RET_IS_STORE(st), .RET_L1_HIT(hit),
        .RET_STORE_EVT(ev), .RET_TRIG_IP(tip), .RET_NEXT_IP(nip), .REC_BUSY(), .REC_VALID(), .REC_OFFSET(),
        .REC_DATA(), .MSR_WR(mwr), .MSR_WDATA(mwd), .MSR_RDATA(rd_srv), .TXN_VALID(tv), .TXN_REQ(req),
        .TXN_SUP(sup), .TXN_SNP(snp), .OCR_MATCH(om_srv));
    always #12.5 clk = ~clk;
    task chk(input [79:0] g, input [79:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task summarize;
        begin
            $display("errors %0d checks %0d", error_cnt, check_count);
            if (error_cnt == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Drives one overflow; drop raises a second overflow mid-record, which must be ignored.
    task rec(input p, input [2:0] sv, input [7:0] k, input drop);
        integer i;
        reg [7:0] eo;
        reg [63:0] ed;
        begin
            @(posedge clk);
            dap <= p;
            ovf <= 1'b1;
            {st, ev, hit} <= sv;
            la <= {8{k}};
            nip <= {8{k ^ 8'h0F}};
            tip <= {8{k ^ 8'hF0}};
            @(posedge clk);
            ovf <= 1'b0;
            #1 chk({78'h0, busy, vld}, 80'h2);
            for (i = 0; i < (p ? 5 : 2); i = i + 1) begin
                @(posedge clk);
                ovf <= drop && i == 0;
                #1;
                eo = (i == 0) ? 8'h08 : (!p || i == 4) ? 8'hB0 : (i == 1) ? 8'h98 : (i == 2) ? 8'hA0 : 8'hA8;
                case (eo)
                    8'h08: ed = nip;
                    8'h98: ed = la;
                    8'hA0: ed = {63'h0, &sv};
                    8'hB0: ed = tip;
                    default: ed = 64'h0;
                endcase
                chk({7'h0, vld, ofs, dat}, {7'h0, 1'b1, eo, ed});
                chk({79'h0, busy}, {79'h0, i < (p ? 4 : 1)});
            end
            repeat (2) begin
                @(posedge clk);
                #1 chk({6'h0, busy, vld, ofs, dat}, 80'h0);
            end
        end
    endtask
    task wrf(input [37:0] v);
        begin
            @(posedge clk);
            mwr <= 1'b1;
            mwd <= v;
            @(posedge clk);
            mwr <= 1'b0;
            #1 chk({42'h0, rd}, {42'h0, v & `SRF_MASK_CLIENT});
            chk({42'h0, rd_l4}, {42'h0, v & `SRF_MASK_L4});
            chk({42'h0, rd_srv}, {42'h0, v & `SRF_MASK_SERVER});
        end
    endtask
    task txn(input [15:0] r, input [13:0] s, input [6:0] q, input e);
        begin
            @(posedge clk);
            tv <= 1'b1;
            req <= r;
            sup <= s;
            snp <= q;
            @(posedge clk);
            tv <= 1'b0;
            #1 chk({79'h0, om}, {79'h0, e});
        end
    endtask
    // Checks the state after the first release, then resets again with a filter loaded.
    task sc_reset;
        begin
            @(posedge clk);
            #1 chk({vld, busy, om, rd}, 80'h0);
            wrf(38'h3FFFFFFFFF);
            @(posedge clk);
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            @(posedge clk);
            #1 chk({vld, busy, om, rd}, 80'h0);
            chk({40'h0, om_l4, om_srv, rd_l4 | rd_srv}, 80'h0);
        end
    endtask
    task sc_records;
        begin
            rec(1'b1, 3'b111, 8'hA1, 1'b0);
            rec(1'b1, 3'b110, 8'h5C, 1'b1);
            rec(1'b1, 3'b101, 8'h33, 1'b0);
            rec(1'b1, 3'b011, 8'hC7, 1'b0);
            rec(1'b0, 3'b111, 8'h96, 1'b0);
        end
    endtask
    task sc_filter;
        begin
            wrf(38'h3FFFFFFFFF);
            wrf(38'h0000000000);
        end
    endtask
    task sc_match;
        begin
            for (n = 0; n < 16; n = n + 1) begin
                wrf((38'h1 << n) | 38'h0000010000);
                txn(16'h1 << n, 14'h0, 7'h0, !(n >= 12 && n <= 14));
                txn(~(16'h1 << n), 14'h0, 7'h0, 1'b0);
            end
            wrf(38'h0000040001);
            txn(16'h1, 14'h2, 7'h0, 1'b1);
            txn(16'h1, 14'h4, 7'h0, 1'b0);
            wrf(38'h0000200001);
            txn(16'h1, 14'h10, 7'h0, 1'b0);
            chk({79'h0, om_srv}, 80'h1);
            chk({79'h0, om_l4}, 80'h0);
            wrf(38'h0000800001);
            txn(16'h1, 14'h40, 7'h0, 1'b0);
            chk({79'h0, om_l4}, 80'h1);
            chk({79'h0, om_srv}, 80'h0);
            wrf(38'h0008000001);
            txn(16'h1, 14'h400, 7'h0, 1'b0);
            chk({79'h0, om_srv}, 80'h1);
            chk({79'h0, om_l4}, 80'h0);
            wrf(38'h0080010001);
            txn(16'h1, 14'h0, 7'h0, 1'b0);
            txn(16'h1, 14'h0, 7'h1, 1'b1);
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        sc_reset;
        sc_filter;
        sc_match;
        sc_records;
        summarize;
    end
endmodule
